//--- hdl/scictl_consts.svh
// Register offsets, field positions and timing constants of the serial control block
`ifndef SCICTL_CONSTS_SVH
`define SCICTL_CONSTS_SVH
`define SCICTL_OFF_CTRL1   4'h0
`define SCICTL_OFF_CTRL2   4'h4
`define SCICTL_OFF_CTRL3   4'h8
`define SCICTL_OFF_STAT    4'hC
`define SCICTL_OFF_DATA    4'h0
`define SCICTL_DATA_BASE   5'h10
// Control 1 fields
`define SCICTL_C1_LOOP     7
`define SCICTL_C1_ON       6
`define SCICTL_C1_LEN      4
`define SCICTL_C1_WAKE     3
`define SCICTL_C1_IDLE     2
`define SCICTL_C1_PEN      1
`define SCICTL_C1_PODD     0
// Control 2 fields
`define SCICTL_C2_TEIE     7
`define SCICTL_C2_TX_DONE_IRQ_ON     6
`define SCICTL_C2_RFIE     5
`define SCICTL_C2_QIE      4
`define SCICTL_C2_TXON     3
`define SCICTL_C2_RXON     2
`define SCICTL_C2_STBY     1
`define SCICTL_C2_BRK      0
// Control 3 fields
`define SCICTL_C3_R8       7
`define SCICTL_C3_T8       6
// Status fields
`define SCICTL_ST_TE       7
`define SCICTL_ST_TC       6
`define SCICTL_ST_RF       5
`define SCICTL_ST_QUIET    4
`define SCICTL_ST_PERR     0
`define SCICTL_CTRL_RESET  8'h00
`define SCICTL_BAUD_DIV    16
`endif

//--- hdl/scictl_core.sv
// Serial control registers with transmitter, receiver and AXI4-Lite slave
// Summary of operation
// - Loop mode feeds transmit output to receiver
// - Loop needs both enables
// - Module off sets empty, done; masks tx irq
// - Length bit chooses nine or eight bits
// - One start, one stop; 10/11-bit frames
// - Parity sits in character MSB position
// - Parity type: one odd, zero even
// - Wake select: address mark or idle line
// - Idle count starts after stop or start
// - Four enables gate flags onto two requests
// - Transmit enable sends preamble of ones
// - Disable finishes current character, then idles
// - Quick disable-enable queues one idle character
// - Receiver enable; clearing keeps receiver flags
// - Standby blocks rx irq; wake clears standby bit
// - Break toggle sends break then one
// - Held break sends breaks back to back
// - Received ninth bit captured; mirrors bit seven
// - Ninth transmit bit loads with data
// - Reset clears control 1 and 2 bits; ninth transmit bit not reset
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scictl_consts.svh"
module scictl_core import scictl_pkg::*; #(
	parameter int BAUD_DIV = `SCICTL_BAUD_DIV
) (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// AXI4-Lite write
	input  wire logic [4:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [4:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Serial line
	input  wire logic        rxPin,
	output logic             txPin,
	// Interrupt requests
	output logic             txIrq,
	output logic             rxIrq
);
	initial begin
		if (BAUD_DIV < 2) $error("BAUD_DIV must be at least 2");
	end
	logic [7:0] serial_control_1, serial_control_2;
	logic       txNinth, rxNinth;
	logic       txEmpty, txDone, rxFull, rxQuiet, parErr;
	logic [7:0] dataTx, dataRx;
	// Bus capture
	logic        awHeld, wHeld;
	logic [4:0]  awA;
	logic [31:0] wD;
	logic [3:0]  wS;
	wire doWrite = awHeld && wHeld && !bvalid;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld <= 1'b0; wHeld <= 1'b0; awA <= 5'h00; wD <= 32'h0; wS <= 4'h0;
			awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
		end else if (clkEn) begin
			awready <= !awHeld && !awready && awvalid;
			wready  <= !wHeld && !wready && wvalid;
			if (awvalid && awready) begin
				awHeld <= 1'b1; awA <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld <= 1'b1; wD <= wdata; wS <= wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0; wHeld <= 1'b0; bvalid <= 1'b1;
				bresp <= (awA[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	wire wrC1 = doWrite && wS[0] && awA == {1'b0, `SCICTL_OFF_CTRL1};
	wire wrC2 = doWrite && wS[0] && awA == {1'b0, `SCICTL_OFF_CTRL2};
	wire wrC3 = doWrite && wS[0] && awA == {1'b0, `SCICTL_OFF_CTRL3};
	wire wrDat = doWrite && wS[0] && awA == `SCICTL_DATA_BASE;
	wire rdDat = arvalid && arready && araddr == `SCICTL_DATA_BASE;
	wire modOn = serial_control_1[`SCICTL_C1_ON];
	wire len9 = serial_control_1[`SCICTL_C1_LEN];
	wire parOn = serial_control_1[`SCICTL_C1_PEN];
	wire parOdd = serial_control_1[`SCICTL_C1_PODD];
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			serial_control_1 <= `SCICTL_CTRL_RESET;
		end else if (clkEn && wrC1) begin
			serial_control_1 <= wD[7:0] & 8'hDF;
		end
	end
	logic wakeHit;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			serial_control_2 <= `SCICTL_CTRL_RESET;
		end else if (clkEn) begin
			if (wrC2) begin
				serial_control_2 <= wD[7:0];
			end else if (wakeHit) begin
				serial_control_2[`SCICTL_C2_STBY] <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (clkEn && wrC3) begin
			txNinth <= wD[`SCICTL_C3_T8];
		end
	end
	// Baud tick, only while module on
	logic [15:0] baudCnt;
	logic        tick;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			baudCnt <= 16'h0; tick <= 1'b0;
		end else if (clkEn) begin
			tick <= modOn && baudCnt == 16'(BAUD_DIV - 1);
			baudCnt <= (!modOn || baudCnt == 16'(BAUD_DIV - 1)) ? 16'h0 : baudCnt + 16'h1;
		end
	end
	// Transmitter
	scictl_tx_t   txSt;
	scictl_kind_t txKind;
	logic [3:0]   txBit;
	logic         dataPend, needPre, needIdle, brkSent, txOnD;
	logic         txLoad, txShift, txLine;
	logic [10:0]  txImg;
	wire          txOn = serial_control_2[`SCICTL_C2_TXON];
	wire          brk = serial_control_2[`SCICTL_C2_BRK];
	wire [3:0]    frameLen = len9 ? 4'hB : 4'hA;
	wire          txPar = parOdd ^ (len9 ? ^dataTx : ^dataTx[6:0]);
	always_comb begin
		txImg = len9 ? {1'b1, txNinth, dataTx, 1'b0} : {2'b11, dataTx, 1'b0};
		if (parOn) begin
			if (len9) begin
				txImg[9] = txPar;
			end else begin
				txImg[8] = txPar;
			end
		end
		if (txKind == KIND_PREAMBLE) begin
			txImg = 11'h7FF;
		end else if (txKind == KIND_BREAK) begin
			// Stop slot low too, so held breaks leave no high gap
			txImg = 11'h000;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txSt <= TX_IDLE; txKind <= KIND_DATA; txBit <= 4'h0; dataPend <= 1'b0;
			needPre <= 1'b0; needIdle <= 1'b0; brkSent <= 1'b0; txOnD <= 1'b0;
			txEmpty <= 1'b1; txDone <= 1'b1; dataTx <= 8'h00; txLoad <= 1'b0; txShift <= 1'b0;
		end else if (clkEn) begin
			txOnD <= txOn;
			txLoad <= 1'b0;
			txShift <= 1'b0;
			if (txOn && !txOnD) begin
				needPre <= 1'b1;
				if (txSt == TX_SHIFT) needIdle <= 1'b1;
			end
			if (wrDat) begin
				dataTx <= wD[7:0]; dataPend <= 1'b1; txEmpty <= 1'b0; txDone <= 1'b0;
			end
			if (txSt == TX_IDLE && tick) begin
				if (txOn) begin
					if ((needPre || needIdle) && !brk) begin
						txKind <= KIND_PREAMBLE; needPre <= 1'b0; needIdle <= 1'b0; txLoad <= 1'b1;
					end else if (brk || brkSent) begin
						txKind <= KIND_BREAK; brkSent <= brk; needPre <= 1'b0; txLoad <= 1'b1;
						if (!brk) begin
							txKind <= KIND_PREAMBLE; txBit <= frameLen - 4'h1;
						end
					end else if (dataPend) begin
						txKind <= KIND_DATA; dataPend <= 1'b0; txEmpty <= 1'b1; txLoad <= 1'b1;
					end else begin
						txDone <= 1'b1;
					end
					if (brk || needPre || needIdle || dataPend) begin
						txDone <= 1'b0; txBit <= 4'h0; txSt <= TX_SHIFT;
					end
				end
			end else if (txSt == TX_SHIFT && tick) begin
				txShift <= 1'b1;
				txBit <= txBit + 4'h1;
				if (txBit == frameLen - 4'h1) begin
					txSt <= TX_IDLE; txShift <= 1'b0;
				end
			end
			if (!modOn) begin
				txEmpty <= 1'b1; txDone <= 1'b1; txSt <= TX_IDLE; dataPend <= 1'b0;
			end
		end
	end
	scictl_shifter #(.WIDTH(11)) uShift (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.clkEn     (clkEn),
		.load      (txLoad),
		.image     (txImg),
		.shift     (txShift),
		.serialOut (txLine)
	);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txPin <= 1'b1;
		end else if (clkEn) begin
			txPin <= txLine;
		end
	end
	// Receiver
	// loop feeds transmit to receiver
	wire rxIn = serial_control_1[`SCICTL_C1_LOOP] ? txLine : rxPin;
	scictl_rx_t rxSt;
	logic [3:0] rxBit;
	logic [9:0] rxSh;
	logic [3:0] onesCnt;
	logic       quietArm;
	wire        rxOn = serial_control_2[`SCICTL_C2_RXON];
	wire        stby = serial_control_2[`SCICTL_C2_STBY];
	wire        wake = serial_control_1[`SCICTL_C1_WAKE];
	wire [9:0]  rxNext = {rxIn, rxSh[9:1]};
	wire        rxLast = rxSt == RX_SHIFT && tick && rxBit == frameLen - 4'h1;
	wire [8:0]  rxChar = len9 ? rxNext[8:0] : {rxNext[8], rxNext[8:1]};
	wire        idleSeen = tick && rxIn && onesCnt == frameLen - 4'h1;
	always_comb begin
		wakeHit = stby && (wake ? (rxLast && rxChar[8]) : idleSeen);
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxSt <= RX_IDLE; rxBit <= 4'h0; rxSh <= 10'h0; onesCnt <= 4'h0; quietArm <= 1'b0;
			rxFull <= 1'b0; rxQuiet <= 1'b0; parErr <= 1'b0; dataRx <= 8'h00;
		end else if (clkEn) begin
			if (rdDat) begin
				rxFull <= 1'b0; rxQuiet <= 1'b0; parErr <= 1'b0;
			end
			if (rxOn && modOn && tick) begin
				if (!rxIn || (rxSt == RX_SHIFT && !serial_control_1[`SCICTL_C1_IDLE]) ? !rxIn : 1'b0) begin
					onesCnt <= 4'h0;
				end else if (onesCnt != 4'hF) begin
					onesCnt <= onesCnt + 4'h1;
				end
				if (rxSt == RX_SHIFT && serial_control_1[`SCICTL_C1_IDLE] && !rxLast) begin
					onesCnt <= 4'h0;
				end
				if (idleSeen && quietArm && !stby) begin
					rxQuiet <= 1'b1; quietArm <= 1'b0;
				end
				if (rxSt == RX_IDLE && !rxIn) begin
					rxSt <= RX_SHIFT; rxBit <= 4'h1;
				end else if (rxSt == RX_SHIFT) begin
					rxSh <= rxNext; rxBit <= rxBit + 4'h1;
					if (rxLast) begin
						rxSt <= RX_IDLE;
						if (!stby && !wakeHit) begin
							dataRx <= rxChar[7:0]; rxFull <= 1'b1; quietArm <= 1'b1;
							parErr <= parOn && ((len9 ? ^rxChar : ^rxChar[7:0]) != parOdd);
						end
					end
				end
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (clkEn && rxOn && modOn && rxLast && !stby) begin
			rxNinth <= rxChar[8];
		end
	end
	// Read path
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'h0;
		end else if (clkEn) begin
			arready <= !arready && !rvalid && arvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1; rresp <= 2'h0;
				case (araddr)
					{1'b0, `SCICTL_OFF_CTRL1}: rdata <= {24'h0, serial_control_1};
					{1'b0, `SCICTL_OFF_CTRL2}: rdata <= {24'h0, serial_control_2};
					{1'b0, `SCICTL_OFF_CTRL3}: rdata <= {24'h0, rxNinth, txNinth, 6'h0};
					{1'b0, `SCICTL_OFF_STAT}: rdata <= {24'h0, txEmpty, txDone, rxFull, rxQuiet, 3'h0, parErr};
					`SCICTL_DATA_BASE: rdata <= {24'h0, dataRx};
					default: begin
						rdata <= 32'h0; rresp <= 2'h2;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txIrq <= 1'b0; rxIrq <= 1'b0;
		end else if (clkEn) begin
			txIrq <= modOn && ((txEmpty && serial_control_2[`SCICTL_C2_TEIE])
				|| (txDone && serial_control_2[`SCICTL_C2_TX_DONE_IRQ_ON]));
			rxIrq <= !stby && ((rxFull && serial_control_2[`SCICTL_C2_RFIE])
				|| (rxQuiet && serial_control_2[`SCICTL_C2_QIE]));
		end
	end
	// tx irq off while module off
	txOffIrq_a: assert property (@(posedge core_clk) disable iff (!nrst)
		clkEn && !modOn |=> !txIrq)
		else $error("tx request while module off");
	txOffFlags_a: assert property (@(posedge core_clk) disable iff (!nrst)
		clkEn && !modOn |=> txEmpty && txDone)
		else $error("tx flags clear while module off");
	rxKeep_a: assert property (@(posedge core_clk) disable iff (!nrst)
		clkEn && !rxOn && !rdDat |=> $stable(rxFull))
		else $error("rx flag changed while off");
	txIdleHigh_a: assert property (@(posedge core_clk) disable iff (!nrst)
		txSt == TX_IDLE && !txLoad && txKind != KIND_BREAK |-> txLine)
		else $error("tx line low when idle");
	breakLow_a: assert property (@(posedge core_clk) disable iff (!nrst)
		txKind == KIND_BREAK && !txLoad |-> !txLine)
		else $error("tx line high during break");
	standbyExit_a: assert property (@(posedge core_clk) disable iff (!nrst)
		clkEn && wakeHit && !wrC2 |=> !stby)
		else $error("standby kept after wake");
	coverTx_c: cover property (@(posedge core_clk) txLoad && txKind == KIND_DATA);
	coverRx_c: cover property (@(posedge core_clk) rxLast);
	coverBrk_c: cover property (@(posedge core_clk) txLoad && txKind == KIND_BREAK);
endmodule : scictl_core
`default_nettype wire

//--- hdl/scictl_pkg.sv
// Types shared by the serial control block
package scictl_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} scictl_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} scictl_rx_t;
	typedef enum logic [1:0] {KIND_DATA, KIND_PREAMBLE, KIND_BREAK} scictl_kind_t;
endpackage : scictl_pkg

//--- hdl/scictl_shifter.sv
// Frame shifter: loads a frame image and moves it out LSB first
`timescale 1ns/1ps
`default_nettype none
module scictl_shifter #(
	parameter int WIDTH = 11
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic             clkEn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] image,
	input  wire logic             shift,
	// Serial out
	output logic                  serialOut
);
	initial begin
		if (WIDTH < 11) $error("shifter too narrow");
	end
	logic [WIDTH-1:0] sreg;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sreg <= '1;
		end else if (clkEn) begin
			if (load) begin
				sreg <= image;
			end else if (shift) begin
				sreg <= {1'b1, sreg[WIDTH-1:1]};
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			serialOut <= 1'b1;
		end else if (clkEn) begin
			serialOut <= load ? image[0] : (shift ? sreg[1] : sreg[0]);
		end
	end
endmodule : scictl_shifter
`default_nettype wire

//--- tb/sci_control_registers_tb_top.sv
// Register-level testbench of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "scictl_consts.svh"
module sci_control_registers_tb_top;
	localparam int         BD = 4;
	localparam logic [4:0] A1 = {1'b0, `SCICTL_OFF_CTRL1};
	localparam logic [4:0] A2 = {1'b0, `SCICTL_OFF_CTRL2};
	localparam logic [4:0] A3 = {1'b0, `SCICTL_OFF_CTRL3};
	localparam logic [4:0] AS = {1'b0, `SCICTL_OFF_STAT};
	localparam logic [4:0] AD = `SCICTL_DATA_BASE;

	logic        core_clk = 1'b0;
	logic        nrst, clkEn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, rxPin, txPin, txIrq, rxIrq, sb;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [8:0]  w;
	realtime     t0;
	int          n_fail = 0;
	int          samples_checked = 0;

	always #20 core_clk = ~core_clk;

	scictl_core #(.BAUD_DIV(BD)) dut_u (
		.core_clk, .nrst, .clkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rxPin, .txPin, .txIrq, .rxIrq
	);

	scictl_peer #(.BAUD_DIV(BD)) peer_u (.core_clk, .txPin, .rxPin);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Handshakes read at the falling edge are those taken at the next rising edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bit aw, wd, b;
		int n;
		aw = 1;
		wd = 1;
		b = 0;
		n = 0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 200) begin
			@(negedge core_clk);
			aw = aw && (awready !== 1'b1);
			wd = wd && (wready !== 1'b1);
			b = (bvalid === 1'b1);
			resp = bresp;
			@(posedge core_clk);
			awvalid <= aw;
			wvalid <= wd;
			if (b)
				bready <= 1'b0;
			n++;
		end
		chk("write answer", 1, b);
	endtask : wr

	task automatic rdr(input logic [4:0] a, output logic [31:0] d);
		bit ar, r;
		int n;
		ar = 1;
		r = 0;
		n = 0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r && n < 200) begin
			@(negedge core_clk);
			ar = ar && (arready !== 1'b1);
			r = (rvalid === 1'b1);
			d = rdata;
			resp = rresp;
			@(posedge core_clk);
			arvalid <= ar;
			if (r)
				rready <= 1'b0;
			n++;
		end
		chk("read answer", 1, r);
	endtask : rdr

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	initial begin
		#800000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		nrst = 1'b0;
		clkEn = 1'b1;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'h1;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		rdr(A1, rd); chk("ctrl1 reset", 32'h0, rd);
		rdr(A2, rd); chk("ctrl2 reset", 32'h0, rd);
		rdr(AS, rd); chk("empty done while off", 32'hC0, rd & 32'hC0);
		rdr(5'h14, rd); chk("unmapped resp", 32'h2, {30'h0, resp});
		wr(A1, 8'hDF); rdr(A1, rd); chk("ctrl1 rw", 32'hDF, rd);
		wr(A1, 8'h40);
		for (int i = 0; i < 2; i++) begin
			wr(A2, 8'h80 >> i);
			repeat (3) @(posedge core_clk);
			chk("txIrq enabled", 1, txIrq);
			wr(A1, 8'h00);
			repeat (3) @(posedge core_clk);
			chk("txIrq module off", 0, txIrq);
			wr(A1, 8'h40);
		end
		wr(A2, 8'h08);
		t0 = $realtime;
		wr(AD, 8'hA5);
		peer_u.catch_word(8, w, sb);
		chk("preamble length", 1, (peer_u.startT - t0) >= (10 * BD - 4) * 40);
		chk("tx byte", 32'hA5, {23'h0, w});
		chk("tx stop", 1, sb);
		for (int p = 0; p < 2; p++) begin
			wr(A1, {7'h21, p[0]});
			wr(AD, 8'h35);
			peer_u.catch_word(8, w, sb);
			chk("parity frame", {24'h0, p[0], 7'h35}, {23'h0, w});
		end
		wr(A1, 8'h58);
		wr(A3, 8'h40);
		fork
			peer_u.catch_word(9, w, sb);
			begin
				wr(AD, 8'h3C);
				wait (txPin === 1'b0);
				wr(A2, 8'h00);
			end
		join
		chk("nine-bit tx", 32'h13C, {23'h0, w});
		chk("stop after disable", 1, sb);
		wr(A2, 8'h26);
		peer_u.send(9'h15A, 9);
		repeat (2 * BD) @(posedge core_clk);
		rdr(A2, rd); chk("standby wake", 32'h24, rd);
		wr(A2, 8'h24);
		peer_u.send(9'h15A, 9);
		repeat (2 * BD) @(posedge core_clk);
		chk("rxIrq full", 1, rxIrq);
		wr(A2, 8'h20);
		rdr(AS, rd); chk("full kept rx off", 32'h20, rd & 32'h20);
		rdr(A3, rd); chk("rx ninth", 32'h80, rd & 32'h80);
		rdr(AD, rd); chk("rx data", 32'h5A, rd);
		wr(A1, 8'hC0);
		wr(A2, 8'h0C);
		fork
			peer_u.send(9'h000, 8);
			wr(AD, 8'h43);
		join
		peer_u.catch_word(8, w, sb);
		chk("loop tx", 32'h43, {23'h0, w});
		repeat (2 * BD) @(posedge core_clk);
		rdr(AD, rd); chk("loop data", 32'h43, rd);
		rdr(A3, rd); chk("ninth mirrors bit7", 32'h00, rd & 32'h80);
		wr(A1, 8'h40);
		wr(A2, 8'h09);
		repeat (2) begin
			peer_u.catch_word(8, w, sb);
			chk("held break", 32'h0, {22'h0, w, sb});
		end
		wr(A2, 8'h08);
		repeat (14 * BD) @(posedge core_clk);
		chk("high after break", 1, txPin);
		report_and_stop();
	end
endmodule : sci_control_registers_tb_top
`default_nettype wire

//--- tb/scictl_peer.sv
// Remote serial peer: sends frames on the receive line and catches frames from the transmit line
`timescale 1ns/1ps
`default_nettype none
module scictl_peer #(
	parameter int BAUD_DIV = 4
) (
	// Clock
	input  wire logic core_clk,
	// Serial line
	input  wire logic txPin,
	output logic      rxPin
);
	realtime startT;

	initial rxPin = 1'b1;

	// start low, data LSB first, stop high
	task automatic send(input logic [8:0] w, input int nb);
		for (int i = 0; i < nb + 2; i++) begin
			@(posedge core_clk);
			rxPin <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : w[i-1];
			repeat (BAUD_DIV - 1) @(posedge core_clk);
		end
	endtask : send

	// Mid-bit sampling on the falling edge, away from the launching edge
	task automatic catch_word(input int nb, output logic [8:0] w, output logic stopBit);
		int n;
		n = 0;
		w = 'x;
		stopBit = 1'bx;
		while (txPin !== 1'b0 && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 4000)
			return;
		startT = $realtime;
		w = '0;
		repeat (BAUD_DIV / 2) @(negedge core_clk);
		for (int i = 0; i < nb; i++) begin
			repeat (BAUD_DIV) @(negedge core_clk);
			w[i] = txPin;
		end
		repeat (BAUD_DIV) @(negedge core_clk);
		stopBit = txPin;
	endtask : catch_word
endmodule : scictl_peer
`default_nettype wire
